// ---- rtl/ascp_ctrl.sv ----
/*
 power and mode control of a serial successive-approximation converter: frame
 counting, power state choice at select rise, track/hold and serial result output.
 assumes chip-select and serial clock come from the host on pins, asynchronous to
 ref_clk and at least four ref_clk cycles per level; the result word comes from the
 analog core and is stable when taken at select fall.
*/
// Notes on behaviour
// - sample input, start conversion on select fall
// - rise after tenth edge aborts, stays powered
// - rise between edges two and ten powers down
// - analog circuitry off during power-down
// - rise before second edge keeps normal mode
// - dummy conversion powers up past tenth edge
// - fully powered after sixteen clocks of dummy
// - early rise during power-up returns power-down
// - power-up time one microsecond suffices
// - dummy: track resumes on first clock edge after fall
// - track-and-hold starts in track at power-up
// - frame is four zeros then result MSB-first
// - select fall holds sample, drives result line
// - each falling clock edge shifts next bit
`timescale 1ns/100ps
`include "ascp_defines.svh"
module ascp_ctrl
   import ascp_pkg::*;
#(
   parameter int RESULT_W = `ASCP_RESULT_W // 12 or 10; 10 gets two trailing zeros
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic chipSelN, // host select pin, active low
   input wire logic serialClk, // host serial clock pin
   input wire logic [RESULT_W-1:0] convResult, // result from the analog core
   output logic serialResultOut, // serial_result_line data
   output logic serialResultOe, // high while the result line is driven
   output logic analogPowerOn, // analog circuitry enable
   output logic trackMode, // high = track, low = hold
   output logic sampleStrobe, // one-cycle pulse: sample input, start conversion
   output logic powerReady, // analog core fully powered
   output logic [2:0] powerState // current power state code
);
   localparam int CW = `ASCP_CNT_W;
   localparam int PW = `ASCP_PWR_CNT_W;
   localparam logic [CW-1:0] FRAME = CW'(`ASCP_FRAME_BITS);
   localparam logic [CW-1:0] PD_LO = CW'(`ASCP_PD_LOW_EDGE);
   localparam logic [CW-1:0] PD_HI = CW'(`ASCP_PD_HIGH_EDGE);
   localparam logic [CW-1:0] TRK = CW'(`ASCP_TRACK_EDGE);
   localparam logic [PW-1:0] PWRUP_CYC = PW'(`ASCP_PWRUP_CYC);
   // the power-up count is in clock cycles, so a faster clock needs a wider
   // counter: the width in the header must grow with it

   // pin events reach this clock only through the sampler below
   ascp_link_if link (); // synchronised events

   // pin sampler: two flops per pin, then edge finding
   ascp_pin_sync u_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .chipSelN(chipSelN),
      .serialClk(serialClk),
      .link(link)
   );

   ascp_pwr_t pwr_ff, nxt_pwr; // power state
   logic [CW-1:0] edges_ff, nxt_edges; // falling edges since select fall
   logic active_ff, nxt_active; // frame in progress
   logic [`ASCP_FRAME_BITS-1:0] shift_ff, nxt_shift; // outgoing frame word
   logic oe_ff, nxt_oe; // result line driven
   logic track_ff, nxt_track; // track-and-hold state
   logic sample_ff, nxt_sample; // sample strobe
   logic dummy_ff, nxt_dummy; // current frame is a power-up attempt
   logic [PW-1:0] pwrCnt_ff, nxt_pwrCnt; // power-up settling count
   logic ready_ff, nxt_ready; // core settled

   // frame word: leading zeros, result MSB first, zero padding after
   // the result is widened and shifted up, so a 12-bit result needs no
   // zero-width padding field, which some front ends refuse
   localparam int FW = `ASCP_FRAME_BITS; // frame length
   localparam int PAD = `ASCP_FRAME_BITS - `ASCP_LEAD_ZEROS - RESULT_W; // trailing zeros
   logic [`ASCP_FRAME_BITS-1:0] frameWord;
   assign frameWord = FW'(convResult) << PAD;

   // next-state logic for the whole control core
   // priority within one cycle: a select fall opens a frame, a select rise
   // closes it, and only inside an open frame are serial clock edges counted;
   // the pins hold each level for several cycles, so two of these never meet
   always_comb begin
      nxt_pwr = pwr_ff;
      nxt_edges = edges_ff;
      nxt_active = active_ff;
      nxt_shift = shift_ff;
      nxt_oe = oe_ff;
      nxt_track = track_ff;
      nxt_sample = 1'b0;
      nxt_dummy = dummy_ff;
      nxt_pwrCnt = pwrCnt_ff;
      nxt_ready = ready_ff;
      if (link.selFall) begin
         // new frame: hold the sample and drive the line
         nxt_active = 1'b1;
         nxt_edges = '0;
         nxt_shift = frameWord; // first leading zero appears now
         nxt_oe = 1'b1;
         nxt_track = 1'b0;
         nxt_sample = (pwr_ff == ASCP_NORMAL);
         nxt_dummy = (pwr_ff == ASCP_POWERDOWN);
         if (pwr_ff == ASCP_POWERDOWN) begin
            nxt_pwr = ASCP_POWERUP;
            nxt_pwrCnt = '0;
            nxt_ready = 1'b0;
         end
      end else if (link.selRise && active_ff) begin
         // decide the power state from the edge count
         nxt_active = 1'b0;
         nxt_oe = 1'b0;
         nxt_track = 1'b1;
         unique case (pwr_ff)
            ASCP_NORMAL: begin
               if (edges_ff >= PD_LO && edges_ff < PD_HI) begin
                  nxt_pwr = ASCP_POWERDOWN;
                  nxt_track = 1'b0; // held while down
                  nxt_ready = 1'b0; // core no longer settled
               end // else stays normal
            end
            ASCP_POWERUP: begin
               if (edges_ff < PD_HI) begin
                  nxt_pwr = ASCP_POWERDOWN;
                  nxt_track = 1'b0;
                  nxt_ready = 1'b0;
               end else begin
                  nxt_pwr = ASCP_NORMAL;
               end
            end
            ASCP_POWERDOWN: nxt_pwr = ASCP_POWERDOWN;
         endcase
      end else if (active_ff) begin
         // dummy cycle: track resumes on first clock edge of either kind
         if (dummy_ff && (link.sclkFall || link.sclkRise) && edges_ff == '0) begin
            nxt_track = 1'b1;
         end
         if (link.sclkFall && edges_ff < FRAME) begin
            nxt_edges = edges_ff + CW'(1);
            nxt_shift = {shift_ff[`ASCP_FRAME_BITS-2:0], 1'b0};
            if (edges_ff + CW'(1) == FRAME) begin
               nxt_oe = 1'b0; // line released on the last falling edge
               if (pwr_ff == ASCP_POWERUP) begin
                  nxt_pwr = ASCP_NORMAL;
                  nxt_ready = 1'b1;
               end
            end
         end
         // normal conversion: track again on the rise after edge thirteen
         if (!dummy_ff && link.sclkRise && edges_ff >= TRK) begin
            nxt_track = 1'b1;
         end
      end
      // settling timer, a fast dummy cycle can end before it runs out
      // the timer alone does not decide the state: a host that clocks fast may
      // finish sixteen edges before it runs out, and then the edge count wins
      if (pwr_ff == ASCP_POWERUP && !link.selFall && pwrCnt_ff != PWRUP_CYC) begin
         nxt_pwrCnt = pwrCnt_ff + PW'(1);
      end else if (pwr_ff == ASCP_POWERUP && pwrCnt_ff == PWRUP_CYC && nxt_pwr != ASCP_POWERDOWN) begin
         // an abort in this same cycle wins over the timer
         nxt_ready = 1'b1;
      end
      if (nxt_pwr == ASCP_NORMAL && pwr_ff == ASCP_POWERUP) begin
         nxt_ready = 1'b1;
      end
   end

   // registers; reset stands for supply application: normal, tracking
   // a real part may wake in either mode; starting in normal is the case in
   // which a host that skips the dummy cycle still finds the input tracking
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pwr_ff <= ASCP_NORMAL;
         edges_ff <= '0;
         active_ff <= 1'b0;
         shift_ff <= '0;
         oe_ff <= 1'b0;
         track_ff <= 1'b1;
         sample_ff <= 1'b0;
         dummy_ff <= 1'b0;
         pwrCnt_ff <= '0;
         ready_ff <= 1'b1;
      end else begin
         pwr_ff <= nxt_pwr;
         edges_ff <= nxt_edges;
         active_ff <= nxt_active;
         shift_ff <= nxt_shift;
         oe_ff <= nxt_oe;
         track_ff <= nxt_track;
         sample_ff <= nxt_sample;
         dummy_ff <= nxt_dummy;
         pwrCnt_ff <= nxt_pwrCnt;
         ready_ff <= nxt_ready;
      end
   end

   // outputs; analog power off only in power-down
   // power-up keeps the core on so that settling can proceed
   assign serialResultOut = shift_ff[`ASCP_FRAME_BITS-1];
   assign serialResultOe = oe_ff;
   assign analogPowerOn = (pwr_ff != ASCP_POWERDOWN);
   assign trackMode = track_ff;
   assign sampleStrobe = sample_ff;
   assign powerReady = ready_ff;
   assign powerState = pwr_ff;

   // checks
   // each one watches what the core drives; the pin events are its inputs
   powerdown_entry_a: assert property (@(posedge ref_clk) disable iff (reset)
      (link.selRise && active_ff && pwr_ff == ASCP_NORMAL && edges_ff >= PD_LO && edges_ff < PD_HI)
      |=> (pwr_ff == ASCP_POWERDOWN && !serialResultOe))
      else $error("select rise in window did not power down");
   glitch_ignore_a: assert property (@(posedge ref_clk) disable iff (reset)
      (link.selRise && active_ff && pwr_ff == ASCP_NORMAL && edges_ff < PD_LO) |=> pwr_ff == ASCP_NORMAL)
      else $error("early select rise changed mode");
   late_abort_a: assert property (@(posedge ref_clk) disable iff (reset)
      (link.selRise && active_ff && pwr_ff == ASCP_NORMAL && edges_ff >= PD_HI)
      |=> (pwr_ff == ASCP_NORMAL && !serialResultOe))
      else $error("late rise did not abort while powered");
   analog_off_a: assert property (@(posedge ref_clk) disable iff (reset)
      pwr_ff == ASCP_POWERDOWN |-> (!analogPowerOn && !trackMode))
      else $error("analog active in power-down");
   powerup_abort_a: assert property (@(posedge ref_clk) disable iff (reset)
      (link.selRise && active_ff && pwr_ff == ASCP_POWERUP && edges_ff < PD_HI) |=> pwr_ff == ASCP_POWERDOWN)
      else $error("short dummy did not return to power-down");
   wake_start_a: assert property (@(posedge ref_clk) disable iff (reset)
      (link.selFall && pwr_ff == ASCP_POWERDOWN) |=> (pwr_ff == ASCP_POWERUP && analogPowerOn))
      else $error("select fall did not start power-up");
   sample_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
      link.selFall |=> (serialResultOe && !trackMode && !serialResultOut))
      else $error("select fall did not hold and drive");
   sample_start_a: assert property (@(posedge ref_clk) disable iff (reset)
      (link.selFall && pwr_ff == ASCP_NORMAL) |=> sampleStrobe ##1 !sampleStrobe)
      else $error("no single sample strobe");
   shift_step_a: assert property (@(posedge ref_clk) disable iff (reset)
      (active_ff && link.sclkFall && !link.selRise && edges_ff < FRAME - CW'(1))
      |=> serialResultOut == $past(shift_ff[`ASCP_FRAME_BITS-2]))
      else $error("result bit did not advance");
   powerup_done_a: assert property (@(posedge ref_clk) disable iff (reset)
      (pwr_ff == ASCP_POWERUP && active_ff && link.sclkFall && !link.selRise && edges_ff == FRAME - CW'(1))
      |=> (pwr_ff == ASCP_NORMAL && powerReady))
      else $error("not powered after sixteen clocks");
   track_resume_a: assert property (@(posedge ref_clk) disable iff (reset)
      (dummy_ff && active_ff && !link.selRise && (link.sclkFall || link.sclkRise) && edges_ff == '0) |=> trackMode)
      else $error("track not resumed in dummy");
   settle_time_a: assert property (@(posedge ref_clk) disable iff (reset)
      (pwr_ff == ASCP_POWERUP && pwrCnt_ff == PWRUP_CYC && !link.selRise) |=> powerReady)
      else $error("not ready after power-up time");

   // frame shape, counting and the result line
   frame_load_a: assert property (@(posedge ref_clk) disable iff (reset)
      link.selFall
      |=> shift_ff == $past(frameWord))
      else $error("frame word not loaded at select fall");
   edge_count_a: assert property (@(posedge ref_clk) disable iff (reset)
      (active_ff && link.sclkFall && !link.selRise && edges_ff < FRAME)
      |=> edges_ff == $past(edges_ff) + CW'(1))
      else $error("falling edge not counted");
   last_release_a: assert property (@(posedge ref_clk) disable iff (reset)
      (active_ff && link.sclkFall && !link.selRise && edges_ff == FRAME - CW'(1))
      |=> !serialResultOe)
      else $error("result line still driven after the last bit");
   idle_release_a: assert property (@(posedge ref_clk) disable iff (reset)
      !active_ff
      |-> !serialResultOe)
      else $error("result line driven outside a frame");

   // conversion start and track-and-hold
   strobe_normal_a: assert property (@(posedge ref_clk) disable iff (reset)
      sampleStrobe
      |-> $past(link.selFall && pwr_ff == ASCP_NORMAL))
      else $error("sample strobe outside a normal select fall");
   dummy_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
      (link.selFall && pwr_ff != ASCP_NORMAL)
      |=> !sampleStrobe)
      else $error("dummy frame started a conversion");
   hold_convert_a: assert property (@(posedge ref_clk) disable iff (reset)
      (active_ff && !dummy_ff && edges_ff < TRK)
      |-> !trackMode)
      else $error("track resumed before the conversion ended");

   // power bookkeeping
   ready_down_a: assert property (@(posedge ref_clk) disable iff (reset)
      pwr_ff == ASCP_POWERDOWN
      |-> !powerReady)
      else $error("core reported settled while powered down");
   wake_keep_a: assert property (@(posedge ref_clk) disable iff (reset)
      (link.selRise && active_ff && pwr_ff == ASCP_POWERUP && edges_ff >= PD_HI)
      |=> (pwr_ff == ASCP_NORMAL && powerReady))
      else $error("long dummy did not leave power-down");
endmodule // ascp_ctrl

// ---- rtl/ascp_defines.svh ----
/*
 shared constants for the serial converter power and mode control block.
 assumes it is included by its bare name from every design file that needs a count or a code.
*/
`ifndef ASCP_DEFINES_SVH
`define ASCP_DEFINES_SVH

// frame shape
`define ASCP_FRAME_BITS 16
`define ASCP_LEAD_ZEROS 4
`define ASCP_CNT_W 5
// falling-edge counts that decide the power state at the select rise
`define ASCP_PD_LOW_EDGE 2
`define ASCP_PD_HIGH_EDGE 10
// track returns after this many falling edges in a normal conversion
`define ASCP_TRACK_EDGE 13
// power-up time in nanoseconds and the clock period
`define ASCP_PWRUP_NS 1000
`define ASCP_CLK_NS 5
`define ASCP_PWRUP_CYC ((`ASCP_PWRUP_NS + `ASCP_CLK_NS - 1) / `ASCP_CLK_NS)
`define ASCP_PWR_CNT_W 8
`define ASCP_RESULT_W 12

`endif

// ---- rtl/ascp_pkg.sv ----
/*
 types for the serial converter power and mode control block.
 assumes nothing beyond a SystemVerilog compiler.
*/
package ascp_pkg;
   // power state of the converter core, one-hot
   typedef enum logic [2:0] {
      ASCP_NORMAL = 3'h1,
      ASCP_POWERDOWN = 3'h2,
      ASCP_POWERUP = 3'h4
   } ascp_pwr_t;
endpackage

// ---- rtl/ascp_link_if.sv ----
/*
 interface carrying the synchronised link events from the pin sampler to the control core.
 assumes both ends run on ref_clk.
*/
`timescale 1ns/100ps
interface ascp_link_if;
   logic selFall; // select went low, one-cycle pulse
   logic selRise; // select went high, one-cycle pulse
   logic selLow; // synchronised select level is low
   logic sclkFall; // serial clock falling edge, one-cycle pulse
   logic sclkRise; // serial clock rising edge, one-cycle pulse
   modport sampler (output selFall, selRise, selLow, sclkFall, sclkRise);
   modport core (input selFall, selRise, selLow, sclkFall, sclkRise);
endinterface

// ---- rtl/ascp_pin_sync.sv ----
/*
 two-flop synchronisers and edge finders for chip-select and serial clock.
 assumes the pins are asynchronous to ref_clk and far slower than it.
*/
`timescale 1ns/100ps
module ascp_pin_sync (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic chipSelN,
   input wire logic serialClk,
   ascp_link_if.sampler link
);
   logic [1:0] syncA_ff, nxt_syncA; // first stage, read only by the second
   logic [1:0] syncB_ff, nxt_syncB; // second stage
   logic [1:0] prev_ff, nxt_prev; // delayed copy for edge detection

   // next values: bit 1 select, bit 0 clock
   always_comb begin
      nxt_syncA = {chipSelN, serialClk};
      nxt_syncB = syncA_ff;
      nxt_prev = syncB_ff;
   end

   // register; reset as idle: select high, clock high
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         syncA_ff <= 2'h3;
         syncB_ff <= 2'h3;
         prev_ff <= 2'h3;
      end else begin
         syncA_ff <= nxt_syncA;
         syncB_ff <= nxt_syncB;
         prev_ff <= nxt_prev;
      end
   end

   // edges found only from second stage onward
   assign link.selFall = prev_ff[1] & ~syncB_ff[1];
   assign link.selRise = ~prev_ff[1] & syncB_ff[1];
   assign link.selLow = ~syncB_ff[1];
   assign link.sclkFall = prev_ff[0] & ~syncB_ff[0];
   assign link.sclkRise = ~prev_ff[0] & syncB_ff[0];
endmodule // ascp_pin_sync

// ---- tb/ascp_host_model.sv ----
/*
 host serial master model: drives select and serial clock, reads the result line.
 assumes ref_clk from the bench; the serial clock idles high and stands still between frames.
*/
`timescale 1ns/100ps
module ascp_host_model (
   input wire logic ref_clk,
   output logic chipSelN,
   output logic serialClk,
   input wire logic serialResultOut,
   input wire logic serialResultOe
);
   logic [15:0] rxWord; // word read in the current frame, first bit in the top place
   int nFalls; // falling edges sent since select fell
   // a released line floats, so a late read never matches a real bit
   wire logic rxLine = serialResultOe ? serialResultOut : 1'bz;

   // idle: select high, serial clock parked high
   initial begin
      chipSelN = 1'b1;
      serialClk = 1'b1;
      rxWord = '0;
      nFalls = 0;
   end

   // select fall on a ref edge; the first zero is read before any clock edge
   task automatic csLow();
      @(posedge ref_clk);
      chipSelN <= 1'b0;
      nFalls = 0;
      rxWord = '0;
      #41;
      rxWord[15] = rxLine;
   endtask

   // one 64 ns serial clock cycle; data is read on the rising edge, the slow-clock way
   task automatic sclkCycle();
      serialClk <= 1'b0;
      nFalls++;
      #32;
      serialClk <= 1'b1;
      if (nFalls < 16) begin
         rxWord[15-nFalls] = rxLine;
      end
      #32;
   endtask

   // select rise, then the bus quiet interval before anything else may start
   task automatic csHigh();
      chipSelN <= 1'b1;
      #100;
   endtask

   // whole frame of n falling edges; any n is legal, the count picks the mode
   task automatic frame(input int n);
      csLow();
      repeat (n) sclkCycle();
      csHigh();
   endtask
endmodule // ascp_host_model

// ---- tb/adc_serial_power_mode_control_tb.sv ----
/*
 self-checking bench of the converter power and mode control.
 assumes the host model drives the pins and the result width is 12.
*/
`timescale 1ns/100ps
module adc_serial_power_mode_control_tb
   import ascp_pkg::*;
;
   logic ref_clk; // 200 MHz
   logic reset; // synchronous, active high
   logic chipSelN; // from the host model
   logic serialClk; // from the host model
   logic [11:0] convResult; // result word offered by the analog core
   logic serialResultOut, serialResultOe, analogPowerOn, trackMode, sampleStrobe, powerReady;
   logic [2:0] powerState;
   int errors, n_checks, strobes, cycles;

   ascp_ctrl #(.RESULT_W(12)) i_dut (.ref_clk(ref_clk), .reset(reset), .chipSelN(chipSelN),
      .serialClk(serialClk), .convResult(convResult), .serialResultOut(serialResultOut),
      .serialResultOe(serialResultOe), .analogPowerOn(analogPowerOn), .trackMode(trackMode),
      .sampleStrobe(sampleStrobe), .powerReady(powerReady), .powerState(powerState));
   ascp_host_model i_host (.ref_clk(ref_clk), .chipSelN(chipSelN), .serialClk(serialClk),
      .serialResultOut(serialResultOut), .serialResultOe(serialResultOe));

   // clock generator
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // counts sample strobes; a hang is cut off well past the expected 2900 or so cycles
   always @(posedge ref_clk) begin
      if (sampleStrobe === 1'b1) strobes++;
      cycles++;
      if (cycles == 20000) begin
         errors++;
         summarize();
      end
   end

   // one comparison, four-state exact
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // reset state: normal, powered, tracking, line released
   task automatic test_reset();
      check(16'(powerState), 16'(ASCP_NORMAL));
      check(16'(trackMode), 16'h0001);
      check({serialResultOe, analogPowerOn, powerReady}, 16'h0003);
      $display("test reset done");
   endtask

   // full 16-clock normal frame carrying one result
   task automatic normal_frame(input logic [11:0] value);
      int s;
      @(posedge ref_clk);
      convResult <= value;
      s = strobes;
      i_host.csLow();
      check({trackMode, serialResultOe}, 16'h0001);
      repeat (16) i_host.sclkCycle();
      check(i_host.rxWord, {4'h0, value});
      check(16'(strobes - s), 16'h0001);
      i_host.csHigh();
      check({serialResultOe, trackMode}, 16'h0001);
   endtask

   // back-to-back frames with complementary patterns catch stale bits
   task automatic test_normal();
      normal_frame(12'hA5C);
      normal_frame(12'h5A3);
      $display("test normal done");
   endtask

   // counts at the select rise against the mode they must select
   task automatic test_modes();
      int n [9] = '{0, 1, 2, 9, 10, 9, 16, 10, 16};
      ascp_pwr_t e [9] = '{ASCP_NORMAL, ASCP_NORMAL, ASCP_POWERDOWN, ASCP_POWERDOWN, ASCP_NORMAL,
         ASCP_POWERDOWN, ASCP_NORMAL, ASCP_NORMAL, ASCP_NORMAL};
      for (int i = 0; i < 9; i++) begin
         i_host.frame(n[i]);
         check(16'(powerState), 16'(e[i]));
         check(16'(analogPowerOn), 16'(e[i] != ASCP_POWERDOWN));
         check(16'(powerReady), 16'(e[i] != ASCP_POWERDOWN));
         check(16'(serialResultOe), 16'h0000);
      end
      $display("test modes done");
   endtask

   // dummy frame out of power-down, then a valid conversion
   task automatic test_powerup();
      int s;
      i_host.frame(5);
      check(16'(analogPowerOn), 16'h0000);
      s = strobes;
      i_host.csLow();
      check({analogPowerOn, powerState}, {12'h000, 1'b1, 3'(ASCP_POWERUP)});
      check(16'(trackMode), 16'h0000);
      i_host.sclkCycle();
      check(16'(trackMode), 16'h0001);
      repeat (15) i_host.sclkCycle();
      check(16'(powerReady), 16'h0001);
      i_host.csHigh();
      check(16'(powerState), 16'(ASCP_NORMAL));
      check(16'(strobes - s), 16'h0000);
      normal_frame(12'h3C9);
      $display("test powerup done");
   endtask

   // long dummy frame: select held low past the power-up time, ended after ten edges
   task automatic test_settle();
      i_host.frame(3);
      check(16'(powerState), 16'(ASCP_POWERDOWN));
      i_host.csLow();
      check(16'(powerReady), 16'h0000);
      #1100;
      check({analogPowerOn, powerReady, trackMode}, 16'h0006);
      repeat (10) i_host.sclkCycle();
      i_host.csHigh();
      check({powerReady, powerState}, {12'h000, 1'b1, 3'(ASCP_NORMAL)});
      normal_frame(12'h9E1);
      $display("test settle done");
   endtask

   // main sequence
   initial begin
      reset = 1'b1;
      convResult = 12'h000;
      errors = 0;
      n_checks = 0;
      strobes = 0;
      cycles = 0;
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (5) @(posedge ref_clk);
      test_reset();
      test_normal();
      test_modes();
      test_powerup();
      test_settle();
      summarize();
   end
endmodule // adc_serial_power_mode_control_tb
